// >>> inc/pswc_params.svh
/*
  Offsets, field positions, reset values and counts of the sector write engine.
  Assumes a word-addressed Avalon-MM slave port with 32-bit data.
*/
`ifndef PSWC_PARAMS_SVH
`define PSWC_PARAMS_SVH

// ==========================================================
// register word addresses
`define PSWC_ADDR_DATA 4'h0
`define PSWC_ADDR_FEAT_ERR 4'h1
`define PSWC_ADDR_COUNT 4'h2
`define PSWC_ADDR_SECNUM 4'h3
`define PSWC_ADDR_CYL_LOW 4'h4
`define PSWC_ADDR_CYL_HIGH 4'h5
`define PSWC_ADDR_DRV_HEAD 4'h6
`define PSWC_ADDR_CMD_STAT 4'h7
`define PSWC_ADDR_DEV_CTRL 4'h8

// ==========================================================
// task file array indices (address minus one)
`define PSWC_TF_FEAT 3'h0
`define PSWC_TF_COUNT 3'h1
`define PSWC_TF_SECNUM 3'h2
`define PSWC_TF_CYL_LOW 3'h3
`define PSWC_TF_CYL_HIGH 3'h4
`define PSWC_TF_NUM 5

// ==========================================================
// command codes
`define PSWC_CMD_WRITE28 8'h30
`define PSWC_CMD_RETRY_MASK 8'hFE
`define PSWC_CMD_WRITE48 8'h34

// ==========================================================
// field positions
`define PSWC_DH_LBA_SELECT 6
`define PSWC_DC_HIGH_BYTE_READBACK 7
`define PSWC_ST_BUSY 7
`define PSWC_ST_READY 6
`define PSWC_ST_DEVICE_FAULT 5
`define PSWC_ST_SEEK_COMPLETE 4
`define PSWC_ST_DRQ 3
`define PSWC_ST_ERR 0
`define PSWC_ER_ID_NOT_FOUND 4
`define PSWC_ER_ABORTED 2

// ==========================================================
// reset values and counts
`define PSWC_RST_BYTE 8'h00
`define PSWC_RST_DRV_HEAD 8'hA0
`define PSWC_WORDS_PER_SECTOR 8'hFF
`define PSWC_COUNT28_ZERO 17'h00100
`define PSWC_COUNT48_ZERO 17'h10000
`define PSWC_CHS_SECTORS 8'h3F
`define PSWC_CHS_LAST_HEAD 4'hF

`endif

// >>> inc/pswc_pkg.sv
/*
  Types of the sector write engine: bus carriers, media carriers, states.
  Assumes pswc_params.svh holds every number.
*/
package pswc_pkg;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [3:0] byteenable;
    logic [31:0] writedata;
  } pswc_avs_req_s;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } pswc_avs_rsp_s;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } pswc_word_s;

  typedef struct packed {
    logic valid;
    logic chs;
    logic [47:0] addr;
  } pswc_commit_s;

  // ==========================================================
  // engine states
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_FLUSH,
    ST_WAIT
  } pswc_state_e;

endpackage

// >>> hw/pswc_top.sv
/*
  Sector write engine: task file registers, command decode, word streaming to the media, completion report.
  Assumes a media back end on the same clock that takes words with valid/ready and answers each commit.
*/
// What this block does
// RQ1: codes 30h and 31h both start the same 28-bit sector write.
// RQ2: the low command bit of 30h/31h is ignored; 35h aborts instead of writing.
// RQ3: sector data arrives as 16-bit words through the data register.
// RQ4: each accepted sector is handed to the media and committed.
// RQ5: 28-bit count is eight bits, zero meaning 256 sectors.
// RQ6: an uncorrectable media error stops the write at that sector.
// RQ7: with lba_select clear the start is cylinder, head and sector.
// RQ8: with lba_select set sector number gives address bits 0-7.
// RQ9: cylinder low gives bits 8-15, cylinder high bits 16-23.
// RQ10: head_field gives address bits 24-27 with lba_select set.
// RQ11: 28-bit completion leaves unwritten sector count in sector count.
// RQ12: CHS completion reports cylinder, head, sector of last sector.
// RQ13: LBA completion reports current address in the address registers.
// RQ14: code 34h runs the 48-bit write with identical data transfer.
// RQ15: 48-bit count uses current and previous bytes, zero meaning 65536.
// RQ16: after a 48-bit error the failing address reads back by high_byte_readback.
// RQ17: a host interrupt is raised after every sector.
// RQ18: each address register holds current low byte and previous high byte.
// RQ19: failures report only id_not_found and aborted; status bits limited.
// RQ20: host sets device/head bits 7 and 5, lba_select for 48-bit.
`timescale 1ns/1ps
`include "pswc_params.svh"

module pswc_top
  import pswc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register bus
  input wire pswc_avs_req_s avs_req,
  output pswc_avs_rsp_s avs_rsp,
  // media word stream
  output pswc_word_s media_word,
  input wire logic media_word_ready,
  // media sector commit
  output pswc_commit_s media_commit,
  input wire logic media_done,
  input wire logic media_fail,
  input wire logic media_fault,
  // host interrupt
  output logic host_intrq
);

  // ==========================================================
  // state
  pswc_state_e state_reg;
  pswc_state_e state_next;
  logic [7:0] tf_cur_reg [0:`PSWC_TF_NUM-1];
  logic [7:0] tf_prev_reg [0:`PSWC_TF_NUM-1];
  logic [7:0] drv_head_reg;
  logic hob_reg;
  logic [7:0] error_reg;
  logic err_reg;
  logic fault_reg;
  logic ext_reg;
  logic chs_reg;
  logic [47:0] cur_addr_reg;
  logic [16:0] remain_reg;
  logic [7:0] word_cnt_reg;
  logic rd_ack_reg;
  logic [31:0] rdata_reg;
  logic intrq_reg;
  pswc_word_s word_reg;
  pswc_commit_s commit_reg;

  // ==========================================================
  // decoding
  function automatic logic is_addr(input logic [3:0] a, input logic [3:0] want);
    is_addr = (a == want);
  endfunction

  wire idle = (state_reg == ST_IDLE);
  wire busy = (state_reg == ST_FLUSH) || (state_reg == ST_WAIT);
  wire drq = (state_reg == ST_XFER);
  wire data_sel = is_addr(avs_req.address, `PSWC_ADDR_DATA);
  wire cmd_sel = is_addr(avs_req.address, `PSWC_ADDR_CMD_STAT);
  wire dc_sel = is_addr(avs_req.address, `PSWC_ADDR_DEV_CTRL);
  wire dh_sel = is_addr(avs_req.address, `PSWC_ADDR_DRV_HEAD);
  wire tf_sel = (avs_req.address >= `PSWC_ADDR_FEAT_ERR) && (avs_req.address <= `PSWC_ADDR_CYL_HIGH);
  wire [2:0] tf_idx = 3'(avs_req.address - `PSWC_ADDR_FEAT_ERR);
  wire lane0 = avs_req.byteenable[0];
  wire lanes01 = &avs_req.byteenable[1:0];
  wire [7:0] wbyte = avs_req.writedata[7:0];

  // data writes stall only while the single word slot cannot drain
  wire data_stall = data_sel && word_reg.valid && !media_word_ready;
  wire wait_wr = avs_req.write && data_stall;
  wire wait_rd = avs_req.read && !rd_ack_reg;
  wire wr_take = avs_req.write && !wait_wr;
  wire rd_take = avs_req.read && rd_ack_reg;
  wire word_take = wr_take && data_sel && lanes01 && drq; // RQ3
  wire cmd_take = wr_take && cmd_sel && lane0 && idle;
  // task file ignores host writes while a command runs
  wire tf_take = wr_take && tf_sel && lane0 && idle;
  wire dh_take = wr_take && dh_sel && lane0 && idle;
  wire dc_take = wr_take && dc_sel && lane0;

  // ==========================================================
  // command decode
  wire is_w28 = ((wbyte & `PSWC_CMD_RETRY_MASK) == `PSWC_CMD_WRITE28); // RQ1 RQ2
  wire is_w48 = (wbyte == `PSWC_CMD_WRITE48); // RQ14
  wire cmd_ok = cmd_take && (is_w28 || is_w48);
  wire cmd_bad = cmd_take && !(is_w28 || is_w48);
  wire lba_sel = drv_head_reg[`PSWC_DH_LBA_SELECT];

  wire [7:0] cnt_lo = tf_cur_reg[`PSWC_TF_COUNT];
  wire [7:0] cnt_hi = tf_prev_reg[`PSWC_TF_COUNT];
  wire [16:0] cnt28 = (cnt_lo == 8'h00) ? `PSWC_COUNT28_ZERO : {9'h000, cnt_lo}; // RQ5
  wire [16:0] cnt48 = ({cnt_hi, cnt_lo} == 16'h0000) ? `PSWC_COUNT48_ZERO : {1'b0, cnt_hi, cnt_lo}; // RQ15

  // 28-bit start: head/LBA 27:24, cylinder high/low, sector number
  wire [27:0] start28 = {drv_head_reg[3:0], tf_cur_reg[`PSWC_TF_CYL_HIGH],
                         tf_cur_reg[`PSWC_TF_CYL_LOW], tf_cur_reg[`PSWC_TF_SECNUM]}; // RQ7 RQ8 RQ9 RQ10
  // 48-bit start: previous bytes form the upper half
  wire [47:0] start48 = {tf_prev_reg[`PSWC_TF_CYL_HIGH], tf_prev_reg[`PSWC_TF_CYL_LOW],
                         tf_prev_reg[`PSWC_TF_SECNUM], start28[23:0]}; // RQ18
  wire [47:0] start_addr = is_w48 ? start48 : {20'h00000, start28};
  wire [16:0] start_cnt = is_w48 ? cnt48 : cnt28;

  // ==========================================================
  // address advance; CHS keeps {head, cylinder, sector} in the same slots
  wire [7:0] c_sec = cur_addr_reg[7:0];
  wire [15:0] c_cyl = cur_addr_reg[23:8];
  wire [3:0] c_head = cur_addr_reg[27:24];
  wire sec_wrap = (c_sec >= `PSWC_CHS_SECTORS);
  wire head_wrap = sec_wrap && (c_head == `PSWC_CHS_LAST_HEAD);
  wire [7:0] n_sec = sec_wrap ? 8'h01 : 8'(c_sec + 8'h01);
  wire [3:0] n_head = head_wrap ? 4'h0 : (sec_wrap ? 4'(c_head + 4'h1) : c_head);
  wire [15:0] n_cyl = head_wrap ? 16'(c_cyl + 16'h0001) : c_cyl;
  wire [47:0] next_chs = {20'h00000, n_head, n_cyl, n_sec};
  wire [47:0] next_lba = 48'(cur_addr_reg + 48'h000000000001);
  wire [47:0] next_addr = chs_reg ? next_chs : next_lba; // RQ12

  // ==========================================================
  // sector outcome
  wire sect_end = (state_reg == ST_WAIT) && media_done;
  wire sect_bad = sect_end && (media_fail || media_fault);
  wire sect_good = sect_end && !(media_fail || media_fault);
  wire last_sect = (remain_reg == 17'h00001);
  wire [16:0] remain_dec = 17'(remain_reg - 17'h00001);
  // failing sector stays counted as not written
  wire [16:0] rpt_cnt = sect_bad ? remain_reg : remain_dec; // RQ11
  wire flush_go = (state_reg == ST_FLUSH) && !word_reg.valid;

  // ==========================================================
  // state machine
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (cmd_ok) begin
          state_next = ST_XFER;
        end
      end
      ST_XFER: begin
        if (word_take && (word_cnt_reg == `PSWC_WORDS_PER_SECTOR)) begin
          state_next = ST_FLUSH;
        end
      end
      ST_FLUSH: begin
        if (flush_go) begin
          state_next = ST_WAIT; // RQ4
        end
      end
      ST_WAIT: begin
        if (sect_bad) begin
          state_next = ST_IDLE; // RQ6
        end else if (sect_good) begin
          state_next = last_sect ? ST_IDLE : ST_XFER;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // command context
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      ext_reg <= 1'b0;
      chs_reg <= 1'b0;
      cur_addr_reg <= 48'h000000000000;
      remain_reg <= 17'h00000;
    end else if (cmd_ok) begin
      ext_reg <= is_w48;
      chs_reg <= is_w28 && !lba_sel; // RQ7
      cur_addr_reg <= start_addr;
      remain_reg <= start_cnt;
    end else if (sect_good) begin
      cur_addr_reg <= next_addr;
      remain_reg <= remain_dec;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || cmd_ok || sect_end) begin
      word_cnt_reg <= 8'h00;
    end else if (word_take) begin
      word_cnt_reg <= 8'(word_cnt_reg + 8'h01);
    end
  end

  // ==========================================================
  // status and error
  always_ff @(posedge clock) begin
    if (sys_rst || cmd_ok) begin
      error_reg <= `PSWC_RST_BYTE;
      err_reg <= 1'b0;
      fault_reg <= 1'b0;
    end else if (cmd_bad) begin
      error_reg[`PSWC_ER_ABORTED] <= 1'b1; // RQ19
      err_reg <= 1'b1;
    end else if (sect_bad) begin
      error_reg[`PSWC_ER_ID_NOT_FOUND] <= 1'b1; // RQ19
      err_reg <= 1'b1;
      fault_reg <= ext_reg && media_fault; // RQ19
    end
  end

  wire [7:0] status_byte = {busy, 1'b1, fault_reg, 1'b1, drq, 2'b00, err_reg}; // RQ19

  // ==========================================================
  // interrupt: set wins over the clearing status read
  wire intrq_set = sect_end || cmd_bad; // RQ17
  wire intrq_clr = rd_take && cmd_sel;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      intrq_reg <= 1'b0;
    end else if (intrq_set) begin
      intrq_reg <= 1'b1;
    end else if (intrq_clr) begin
      intrq_reg <= 1'b0;
    end
  end

  // ==========================================================
  // task file: host writes shift current into previous, completion overwrites
  genvar gi;
  generate
    for (gi = 0; gi < `PSWC_TF_NUM; gi = gi + 1) begin : g_tf
      logic rpt_hit;
      logic [7:0] rpt_cur;
      logic [7:0] rpt_prev;
      assign rpt_hit = sect_end && (gi != 0);
      assign rpt_cur = (gi == 1) ? rpt_cnt[7:0] :
                       (gi == 2) ? cur_addr_reg[7:0] :
                       (gi == 3) ? cur_addr_reg[15:8] : cur_addr_reg[23:16]; // RQ13
      assign rpt_prev = (gi == 1) ? rpt_cnt[15:8] :
                        (gi == 2) ? cur_addr_reg[31:24] :
                        (gi == 3) ? cur_addr_reg[39:32] : cur_addr_reg[47:40]; // RQ16
      always_ff @(posedge clock) begin
        if (sys_rst) begin
          tf_cur_reg[gi] <= `PSWC_RST_BYTE;
          tf_prev_reg[gi] <= `PSWC_RST_BYTE;
        end else if (rpt_hit) begin
          tf_cur_reg[gi] <= rpt_cur; // RQ11 RQ12
          if (ext_reg) begin
            tf_prev_reg[gi] <= rpt_prev; // RQ16
          end
        end else if (tf_take && (tf_idx == 3'(gi))) begin
          tf_cur_reg[gi] <= wbyte; // RQ18
          tf_prev_reg[gi] <= tf_cur_reg[gi];
        end
      end
    end
  endgenerate

  // head field tracks the reported address in 28-bit mode
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drv_head_reg <= `PSWC_RST_DRV_HEAD;
    end else if (sect_end && !ext_reg) begin
      drv_head_reg[3:0] <= cur_addr_reg[27:24]; // RQ12 RQ13
    end else if (dh_take) begin
      drv_head_reg <= wbyte; // RQ20
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      hob_reg <= 1'b0;
    end else if (dc_take) begin
      hob_reg <= wbyte[`PSWC_DC_HIGH_BYTE_READBACK];
    end
  end

  // ==========================================================
  // media word slot and commit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      word_reg <= '0;
    end else if (word_take) begin
      word_reg.valid <= 1'b1; // RQ3
      word_reg.data <= avs_req.writedata[15:0];
    end else if (media_word_ready) begin
      word_reg.valid <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      commit_reg <= '0;
    end else begin
      commit_reg.valid <= flush_go; // RQ4
      if (flush_go) begin
        commit_reg.chs <= chs_reg;
        commit_reg.addr <= cur_addr_reg;
      end
    end
  end

  // ==========================================================
  // register read path: one wait cycle, then registered data
  // an eight-slot view keeps the read index in range for every address
  logic [7:0] tf_view [0:7];
  genvar gv;

  generate
    for (gv = 0; gv < 8; gv = gv + 1) begin : g_view
      if (gv < `PSWC_TF_NUM) begin : g_used
        assign tf_view[gv] = hob_reg ? tf_prev_reg[gv] : tf_cur_reg[gv]; // RQ16
      end else begin : g_spare
        assign tf_view[gv] = 8'h00;
      end
    end
  endgenerate

  wire [7:0] tf_rd = tf_view[tf_idx]; // RQ16
  wire [7:0] rd_byte = is_addr(avs_req.address, `PSWC_ADDR_FEAT_ERR) ? error_reg :
                       tf_sel ? tf_rd :
                       dh_sel ? drv_head_reg :
                       cmd_sel ? status_byte :
                       dc_sel ? {hob_reg, 7'h00} : 8'h00;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      rd_ack_reg <= wait_rd;
      if (wait_rd) begin
        rdata_reg <= {24'h000000, rd_byte};
      end
    end
  end

  // ==========================================================
  // outputs
  assign avs_rsp.waitrequest = wait_rd || wait_wr;
  assign avs_rsp.readdata = rdata_reg;
  assign media_word = word_reg;
  assign media_commit = commit_reg;
  assign host_intrq = intrq_reg;

endmodule

// >>> verif/pswc_properties.sv
/* checker: bus and media relations at the engine ports
   assumes a bind onto pswc_top from the bench */
`timescale 1ns/1ps
`include "pswc_params.svh"
module pswc_properties
  import pswc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // register bus
  input wire pswc_avs_req_s avs_req,
  input wire pswc_avs_rsp_s avs_rsp,
  // media side
  input wire pswc_word_s media_word,
  input wire logic media_word_ready,
  input wire pswc_commit_s media_commit,
  input wire logic media_done,
  input wire logic media_fail,
  input wire logic media_fault,
  input wire logic host_intrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // helper state
  logic [8:0] words_reg;
  logic failed_reg;
  logic seq_reg;
  logic [47:0] last_reg;
  wire cmd_wr = avs_req.write && !avs_rsp.waitrequest && avs_req.address == 4'h7;
  always_ff @(posedge clock) begin
    if (sys_rst || media_commit.valid) begin
      words_reg <= 9'h000;
    end else if (media_word.valid && media_word_ready) begin
      words_reg <= words_reg + 9'h001;
    end
  end
  always_ff @(posedge clock) begin
    if (sys_rst || cmd_wr) begin
      failed_reg <= 1'b0;
      seq_reg <= 1'b0;
    end else begin
      failed_reg <= failed_reg || (media_done && (media_fail || media_fault));
      seq_reg <= seq_reg || media_commit.valid;
    end
    if (media_commit.valid) begin
      last_reg <= media_commit.addr;
    end
  end
  // ==========================================================
  // properties
  property p_word_hold;
    media_word.valid && !media_word_ready |=> media_word.valid && $stable(media_word.data);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word dropped before ready");
  property p_commit_pulse;
    media_commit.valid |=> !media_commit.valid;
  endproperty
  a_commit_pulse: assert property (p_commit_pulse) else $error("commit longer than a cycle");
  property p_commit_whole;
    media_commit.valid |-> words_reg == 9'h100 && !media_word.valid;
  endproperty
  a_commit_whole: assert property (p_commit_whole) else $error("commit without full sector");
  property p_fail_stop;
    failed_reg |-> !media_word.valid && !media_commit.valid;
  endproperty
  a_fail_stop: assert property (p_fail_stop) else $error("write went on after failure");
  property p_addr_seq;
    media_commit.valid && seq_reg && !media_commit.chs |-> media_commit.addr == last_reg + 48'h1;
  endproperty
  a_addr_seq: assert property (p_addr_seq) else $error("sectors not consecutive");
  property p_cmd_nowait;
    avs_req.write && avs_req.address == 4'h7 |-> !avs_rsp.waitrequest;
  endproperty
  a_cmd_nowait: assert property (p_cmd_nowait) else $error("command write stalled");
  property p_read_wait;
    $rose(avs_req.read) |-> avs_rsp.waitrequest ##1 !avs_rsp.waitrequest;
  endproperty
  a_read_wait: assert property (p_read_wait) else $error("read answer late");
  property p_intrq_sector;
    media_done |=> host_intrq;
  endproperty
  a_intrq_sector: assert property (p_intrq_sector) else $error("no interrupt after sector");
endmodule

// >>> verif/pswc_media_model.sv
/* media back end model: stalling word intake, delayed commit answer
   assumes fail_next and fault_next from the bench pick each outcome */
`timescale 1ns/1ps
module pswc_media_model
  import pswc_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire pswc_word_s media_word,
  output logic media_word_ready,
  input wire pswc_commit_s media_commit,
  output logic media_done,
  output logic media_fail,
  output logic media_fault,
  input wire logic fail_next,
  input wire logic fault_next
);
  logic [2:0] wait_reg;
  logic busy_reg;
  // qualifiers toggle outside the done pulse so no stale value can pass
  always_ff @(posedge clock) begin
    media_word_ready <= !sys_rst && !media_word_ready;
    media_done <= 1'b0;
    media_fail <= !sys_rst && !media_fail;
    media_fault <= !sys_rst && !media_fault;
    if (sys_rst) begin
      busy_reg <= 1'b0;
    end else if (media_commit.valid) begin
      busy_reg <= 1'b1;
      wait_reg <= 3'h5;
    end else if (busy_reg) begin
      wait_reg <= wait_reg - 3'h1;
      if (wait_reg == 3'h0) begin
        busy_reg <= 1'b0;
        media_done <= 1'b1;
        media_fail <= fail_next;
        media_fault <= fault_next;
      end
    end
  end
endmodule

// >>> verif/tb.sv
/* bench: register bus tasks and command sequences with expected reports
   assumes design, media model and checker compiled before it */
`timescale 1ns/1ps
`include "pswc_params.svh"
module tb
  import pswc_pkg::*;
;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  pswc_avs_req_s avs_req = '0;
  pswc_avs_rsp_s avs_rsp;
  pswc_word_s media_word;
  logic media_word_ready;
  pswc_commit_s media_commit;
  logic media_done;
  logic media_fail;
  logic media_fault;
  logic host_intrq;
  logic fail_next = 1'b0;
  logic fault_next = 1'b0;
  int fail_count = 0;
  int n_tests = 0;
  logic [48:0] cq[$];
  logic [7:0] exp_b = 8'h00;
  always #10 clock = ~clock;
  pswc_top DUT (.clock(clock), .sys_rst(sys_rst), .avs_req(avs_req), .avs_rsp(avs_rsp),
    .media_word(media_word), .media_word_ready(media_word_ready), .media_commit(media_commit),
    .media_done(media_done), .media_fail(media_fail), .media_fault(media_fault), .host_intrq(host_intrq));
  pswc_media_model u_media (.clock(clock), .sys_rst(sys_rst), .media_word(media_word),
    .media_word_ready(media_word_ready), .media_commit(media_commit), .media_done(media_done),
    .media_fail(media_fail), .media_fault(media_fault), .fail_next(fail_next), .fault_next(fault_next));
  // ==========================================================
  // compare and bus tasks
  task automatic chk(input logic [48:0] got, input logic [48:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask
  task automatic bus(input logic rd, input logic [3:0] a, input logic [15:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_req.read <= rd;
    avs_req.write <= !rd;
    avs_req.address <= a;
    avs_req.writedata <= {16'h0000, d};
    @(posedge clock);
    while (avs_rsp.waitrequest !== 1'b0) begin
      @(posedge clock);
    end
    q = avs_rsp.readdata;
    avs_req.read <= 1'b0;
    avs_req.write <= 1'b0;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    logic [31:0] q;
    bus(1'b0, a, d, q);
  endtask
  task automatic rc(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b1, a, 16'h0000, q);
    chk({17'h00000, q}, {17'h00000, e});
  endtask
  task automatic cmd(input logic [7:0] c, n, sn, cl, ch, dh);
    wr(4'h2, {8'h00, n});
    wr(4'h3, {8'h00, sn});
    wr(4'h4, {8'h00, cl});
    wr(4'h5, {8'h00, ch});
    wr(4'h6, {8'h00, dh});
    wr(4'h7, {8'h00, c});
  endtask
  // one sector of words, then wait for the interrupt and read status
  task automatic sector(input logic [31:0] st);
    int i;
    for (i = 0; i < 256; i++) begin
      wr(4'h0, {8'hA5, i[7:0]});
    end
    i = 0;
    while (host_intrq !== 1'b1 && i < 100) begin
      @(posedge clock);
      i++;
    end
    chk({48'h0, host_intrq}, 49'h1);
    rc(4'h7, st);
  endtask
  task automatic pop(input logic [48:0] e);
    chk(cq.size() > 0 ? cq.pop_front() : '1, e);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ==========================================================
  // media side monitor
  always @(posedge clock) begin
    if (media_word.valid && media_word_ready) begin
      chk({33'h0, media_word.data}, {33'h0, 8'hA5, exp_b});
      exp_b <= exp_b + 8'h01;
    end
    if (media_commit.valid) begin
      cq.push_back({media_commit.chs, media_commit.addr});
    end
  end
  initial begin
    #(20 * 20000);
    fail_count++;
    results;
  end
  // ==========================================================
  // sequences
  initial begin
    avs_req.byteenable = 4'hF;
    repeat (12) @(posedge clock);
    sys_rst <= 1'b0;
    rc(4'h7, 32'h50);
    rc(4'h6, 32'hA0);
    cmd(8'h30, 8'h01, 8'h56, 8'h34, 8'h12, 8'hE5);
    sector(32'h50);
    pop({1'b0, 48'h000005123456});
    rc(4'h3, 32'h56);
    rc(4'h2, 32'h00);
    // retry bit set, count two, address carries over a byte edge
    cmd(8'h31, 8'h02, 8'hFF, 8'hFF, 8'h00, 8'hE0);
    sector(32'h58);
    sector(32'h50);
    pop({1'b0, 48'h00000000FFFF});
    pop({1'b0, 48'h000000010000});
    rc(4'h3, 32'h00);
    rc(4'h5, 32'h01);
    rc(4'h2, 32'h00);
    cmd(8'h30, 8'h01, 8'h05, 8'h02, 8'h01, 8'hA3);
    sector(32'h50);
    pop({1'b1, 20'h00000, 4'h3, 16'h0102, 8'h05});
    rc(4'h3, 32'h05);
    rc(4'h4, 32'h02);
    // extended write failing at its first sector
    fail_next <= 1'b1;
    wr(4'h2, 16'h0000);
    wr(4'h3, 16'h0044);
    wr(4'h4, 16'h0055);
    wr(4'h5, 16'h0066);
    cmd(8'h34, 8'h02, 8'h11, 8'h22, 8'h33, 8'h40);
    sector(32'h51);
    pop({1'b0, 48'h665544332211});
    rc(4'h1, 32'h10);
    rc(4'h2, 32'h02);
    rc(4'h3, 32'h11);
    wr(4'h8, 16'h0080);
    rc(4'h3, 32'h44);
    rc(4'h5, 32'h66);
    rc(4'h2, 32'h00);
    wr(4'h8, 16'h0000);
    fail_next <= 1'b0;
    wr(4'h7, 16'h0020);
    rc(4'h7, 32'h51);
    rc(4'h1, 32'h14);
    chk(cq.size(), 49'h0);
    // extended write ending in a device fault; new bytes push the report into previous
    fault_next <= 1'b1;
    cmd(8'h34, 8'h01, 8'h01, 8'h00, 8'h00, 8'h40);
    sector(32'h71);
    fault_next <= 1'b0;
    pop({1'b0, 48'h332211000001});
    rc(4'h1, 32'h10);
    rc(4'h2, 32'h01);
    results;
  end
endmodule
bind pswc_top pswc_properties u_props (.clock(clock), .sys_rst(sys_rst), .avs_req(avs_req),
  .avs_rsp(avs_rsp), .media_word(media_word), .media_word_ready(media_word_ready),
  .media_commit(media_commit), .media_done(media_done), .media_fail(media_fail),
  .media_fault(media_fault), .host_intrq(host_intrq));
